// >>> logic/lfb_pkg.sv
// Purpose: Shared constants for the pixel aperture path and its host end
// Assumes: Byte addresses, 32-bit data words
// Notes:   Register and field positions used by both ends
package lfb_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [31:0] APERTURE_OFFSET = 32'h0080_0000;
  localparam logic [31:0] APERTURE_SIZE   = 32'h0040_0000;
  localparam int          LINE_PIXELS     = 2048;
  localparam logic [31:0] REG_FMT_CTRL    = 32'h0000_0100;
  localparam logic [31:0] REG_PIPE_MODE   = 32'h0000_0104;
  localparam logic [31:0] REG_CONST_DA    = 32'h0000_0108;
  localparam logic [31:0] REG_FLUSH_CMD   = 32'h0000_010c;
  localparam logic [31:0] REG_STATUS      = 32'h0000_0110;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          FMT_CODE_LSB    = 0;
  localparam int          FMT_SWAP_BIT    = 11;
  localparam int          FMT_CHAN_LSB    = 9;
  localparam int          MODE_SCISSOR_BIT = 0;
  localparam int          MODE_YBOT_BIT   = 16;
  localparam int          FLUSH_STATS_BIT = 0;
  localparam int          STATUS_BUSY_BIT = 0;
  localparam logic [31:0] RST_FMT_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_PIPE_MODE   = 32'h0000_0000;
  localparam logic [31:0] RST_CONST_DA    = 32'h0000_0000;

  // ****************************************
  // Write formats
  // ****************************************
  localparam logic [3:0] F_RGB565   = 4'h0;
  localparam logic [3:0] F_XRGB555  = 4'h1;
  localparam logic [3:0] F_ARGB1555 = 4'h2;
  localparam logic [3:0] F_RSVD3    = 4'h3;
  localparam logic [3:0] F_RGB888   = 4'h4;
  localparam logic [3:0] F_ARGB8888 = 4'h5;
  localparam logic [3:0] F_DEP_565  = 4'hc;
  localparam logic [3:0] F_DEP_555  = 4'hd;
  localparam logic [3:0] F_DEP_1555 = 4'he;
  localparam logic [3:0] F_DEP_DEP  = 4'hf;

  // ****************************************
  // Host command registers (Wishbone)
  // ****************************************
  localparam logic [3:0] HREG_ADDR   = 4'h0;
  localparam logic [3:0] HREG_DATA   = 4'h4;
  localparam logic [3:0] HREG_CTRL   = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hc;
  localparam int         HCTRL_GO    = 0;
  localparam int         HCTRL_WRITE = 1;
  localparam int         HCTRL_IDLE  = 2;
  localparam int         HCTRL_BE_LSB = 4;
  localparam int         IDLE_READS  = 3;

endpackage

// >>> logic/lfb_link_if.sv
// Purpose: Memory-access link between host end and device end
// Assumes: One clock; single request outstanding
// Notes:   Request held until ack pulse
interface lfb_link_if;
  logic        req;
  logic        we;
  logic [31:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;

  modport host_end (output req, output we, output addr, output be, output wdata, input ack, input rdata);
  modport dev_end  (input req, input we, input addr, input be, input wdata, output ack, output rdata);
endinterface

// >>> logic/lfb_device.sv
// Purpose: Pixel aperture decode, unpack and blocking read path
// Assumes: Inputs synchronous to clk_i; one request at a time
// Notes:   Lane 1 pixel sits at pix_x_o + 1 on the same line
module lfb_device import lfb_pkg::*; #(
  parameter logic [10:0] SCREEN_W = 11'd640,
  parameter logic [10:0] SCREEN_H = 11'd480
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  lfb_link_if.dev_end      link,
  input  wire logic [31:0] mem_base_config_i,
  input  wire logic        host_fifo_empty_i,
  input  wire logic        pipe_idle_i,
  input  wire logic [31:0] pix_rdata_i,
  input  wire logic        pix_rvalid_i,
  output logic [1:0]       pix_col_we_o,
  output logic [1:0]       pix_dep_we_o,
  output logic [3:0]       pix_be_o,
  output logic [10:0]      pix_x_o,
  output logic [10:0]      pix_y_o,
  output logic [31:0]      pix_color0_o,
  output logic [31:0]      pix_color1_o,
  output logic [15:0]      pix_depth0_o,
  output logic [15:0]      pix_depth1_o,
  output logic             pix_re_o,
  output logic             flush_o,
  output logic             stats_clear_o
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_DRAIN = 4'b0010,
    S_READ  = 4'b0100,
    S_ACK   = 4'b1000
  } state_e;

  state_e      state_r;
  logic [31:0] pixel_aperture_format_control;
  logic [31:0] pixel_pipeline_mode;
  logic [31:0] constant_depth_alpha;
  logic        flush_pend_r;
  logic        ack_r;
  logic [31:0] rdata_r;

  logic [31:0] off;
  logic        in_ap;
  logic [3:0]  fmt;
  logic        wide;
  logic        swap;
  logic [10:0] line;
  logic [10:0] col;
  logic [10:0] ypos;
  logic        clip0;
  logic        clip1;
  logic [15:0] lo_h;
  logic [15:0] hi_h;
  logic [1:0]  half_en;
  logic        drained;
  logic        busy;
  logic        take;

  // ****************************************
  // Pixel unpacking
  // ****************************************
  function automatic logic [31:0] unpack16(input logic [15:0] h, input logic [1:0] f, input logic [7:0] ca);
    logic [7:0] a;
    a = (f == 2'd3) ? {8{h[15]}} : ca;
    if (f == 2'd0) begin
      unpack16 = {a, h[15:11], h[15:13], h[10:5], h[10:9], h[4:0], h[4:2]};
    end else begin
      unpack16 = {a, h[14:10], h[14:12], h[9:5], h[9:7], h[4:0], h[4:2]};
    end
  endfunction

  // Written order to internal ARGB
  function automatic logic [31:0] reorder(input logic [31:0] p, input logic [3:0] ch);
    unique case (ch)
      4'h1:    reorder = {p[31:24], p[7:0], p[15:8], p[23:16]};
      4'h2:    reorder = {p[7:0], p[31:8]};
      4'h3:    reorder = {p[7:0], p[15:8], p[23:16], p[31:24]};
      default: reorder = p;
    endcase
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  assign off   = link.addr - mem_base_config_i - APERTURE_OFFSET;
  assign in_ap = (link.addr >= mem_base_config_i + APERTURE_OFFSET) && (off < APERTURE_SIZE);
  assign fmt   = pixel_aperture_format_control[FMT_CODE_LSB +: 4];
  assign wide  = (fmt == F_RGB888) || (fmt == F_ARGB8888) || (fmt == F_DEP_565) ||
                 (fmt == F_DEP_555) || (fmt == F_DEP_1555);
  assign swap  = pixel_aperture_format_control[FMT_SWAP_BIT];

  // Byte offset = line * bytes per line + column * bytes per pixel
  always_comb begin
    if (wide) begin
      line = {1'b0, off[21:12]};
      col  = {1'b0, off[11:2]};
    end else begin
      line = off[21:11];
      col  = {1'b0, off[10:1]};
    end
  end

  // Column of logical line never exceeds 1024 pixels
  assign ypos  = pixel_pipeline_mode[MODE_YBOT_BIT] ? SCREEN_H - 11'd1 - line : line;
  assign clip0 = pixel_pipeline_mode[MODE_SCISSOR_BIT] && ((col >= SCREEN_W) || (ypos >= SCREEN_H));
  assign clip1 = pixel_pipeline_mode[MODE_SCISSOR_BIT] && ((col + 11'd1 >= SCREEN_W) || (ypos >= SCREEN_H));
  assign lo_h    = swap ? link.wdata[31:16] : link.wdata[15:0];
  assign hi_h    = swap ? link.wdata[15:0] : link.wdata[31:16];
  assign half_en = swap ? {|link.be[1:0], |link.be[3:2]} : {|link.be[3:2], |link.be[1:0]};
  assign drained = host_fifo_empty_i && pipe_idle_i;
  assign busy    = flush_pend_r || !drained;
  assign take    = (state_r == S_IDLE) && link.req && !ack_r;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pixel_aperture_format_control <= RST_FMT_CTRL;
      pixel_pipeline_mode           <= RST_PIPE_MODE;
      constant_depth_alpha          <= RST_CONST_DA;
    end else if (take && link.we && !in_ap) begin
      if (link.addr - mem_base_config_i == REG_FMT_CTRL)
        pixel_aperture_format_control <= link.wdata;
      if (link.addr - mem_base_config_i == REG_PIPE_MODE)
        pixel_pipeline_mode <= link.wdata;
      if (link.addr - mem_base_config_i == REG_CONST_DA)
        constant_depth_alpha <= link.wdata;
    end
  end

  // Flush drains pending work; new request wins over completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_pend_r  <= 1'b0;
      flush_o       <= 1'b0;
      stats_clear_o <= 1'b0;
    end else begin
      flush_o       <= 1'b0;
      stats_clear_o <= 1'b0;
      if (take && link.we && !in_ap && (link.addr - mem_base_config_i == REG_FLUSH_CMD)) begin
        flush_pend_r  <= 1'b1;
        flush_o       <= 1'b1;
        stats_clear_o <= link.wdata[FLUSH_STATS_BIT];
      end else if (drained && !flush_o) begin
        flush_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pixel write lanes
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_col_we_o <= 2'b00;
      pix_dep_we_o <= 2'b00;
      pix_be_o     <= 4'h0;
      pix_x_o      <= 11'd0;
      pix_y_o      <= 11'd0;
      pix_color0_o <= 32'h0000_0000;
      pix_color1_o <= 32'h0000_0000;
      pix_depth0_o <= 16'h0000;
      pix_depth1_o <= 16'h0000;
    end else begin
      pix_col_we_o <= 2'b00;
      pix_dep_we_o <= 2'b00;
      if (take && in_ap) begin
        pix_x_o      <= col;
        pix_y_o      <= ypos;
        pix_be_o     <= link.be;
        pix_depth0_o <= constant_depth_alpha[15:0];
        pix_depth1_o <= constant_depth_alpha[15:0];
      end
      if (take && in_ap && link.we) begin
        unique case (fmt)
          F_RGB565, F_XRGB555, F_ARGB1555, F_RSVD3: begin
            pix_color0_o <= reorder(unpack16(lo_h, fmt[1:0], constant_depth_alpha[31:24]),
                                    pixel_aperture_format_control[FMT_CHAN_LSB +: 4]);
            pix_color1_o <= reorder(unpack16(hi_h, fmt[1:0], constant_depth_alpha[31:24]),
                                    pixel_aperture_format_control[FMT_CHAN_LSB +: 4]);
            pix_col_we_o <= {half_en[1] && !clip1, half_en[0] && !clip0};
            pix_dep_we_o <= {half_en[1] && !clip1, half_en[0] && !clip0};
          end
          F_RGB888, F_ARGB8888: begin
            pix_color0_o <= reorder(link.wdata, pixel_aperture_format_control[FMT_CHAN_LSB +: 4]);
            pix_col_we_o <= {1'b0, (|link.be) && !clip0};
            pix_dep_we_o <= {1'b0, (|link.be) && !clip0};
          end
          F_DEP_565, F_DEP_555, F_DEP_1555: begin
            pix_color0_o <= reorder(unpack16(lo_h, fmt[1:0], constant_depth_alpha[31:24]),
                                    pixel_aperture_format_control[FMT_CHAN_LSB +: 4]);
            pix_depth0_o <= hi_h;
            pix_col_we_o <= {1'b0, half_en[0] && !clip0};
            pix_dep_we_o <= {1'b0, half_en[1] && !clip0};
          end
          F_DEP_DEP: begin
            pix_depth0_o <= lo_h;
            pix_depth1_o <= hi_h;
            pix_dep_we_o <= {half_en[1] && !clip1, half_en[0] && !clip0};
          end
          default: begin
            pix_col_we_o <= 2'b00; // Codes 6 to b write nothing
          end
        endcase
      end
    end
  end

  // ****************************************
  // Request sequencing
  // ****************************************
  // Aperture reads stall the link until the host FIFO and pipeline drain; no timeout by design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r  <= S_IDLE;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      pix_re_o <= 1'b0;
    end else begin
      ack_r    <= 1'b0;
      pix_re_o <= 1'b0;
      unique case (state_r)
        S_IDLE: if (take) begin
          if (in_ap && !link.we) begin
            state_r <= S_DRAIN;
          end else begin
            ack_r   <= 1'b1;
            rdata_r <= (!link.we && (link.addr - mem_base_config_i == REG_STATUS)) ?
                       {31'd0, busy} : 32'h0000_0000;
            state_r <= S_ACK;
          end
        end
        S_DRAIN: if (drained && !flush_pend_r) begin
          pix_re_o <= 1'b1;
          state_r  <= S_READ;
        end
        S_READ: if (pix_rvalid_i) begin
          rdata_r <= pix_rdata_i;
          ack_r   <= 1'b1;
          state_r <= S_ACK;
        end
        S_ACK: state_r <= S_IDLE;
      endcase
    end
  end

  assign link.ack   = ack_r;
  assign link.rdata = rdata_r;

endmodule // lfb_device

// >>> logic/lfb_host.sv
// Purpose: Host end issuing aperture and register accesses
// Assumes: Software drives classic Wishbone; inputs synchronous
// Notes:   Idle check flushes then needs three clean status reads
module lfb_host import lfb_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  lfb_link_if.host_end     link,
  input  wire logic [31:0] mem_base_config_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_XFER  = 4'b0010,
    H_FLUSH = 4'b0100,
    H_POLL  = 4'b1000
  } hstate_e;

  hstate_e     st_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic        idle_ok_r;
  logic [1:0]  clean_r;
  logic        req_r;
  logic        we_r;
  logic [31:0] la_r;
  logic [3:0]  be_r;
  logic [31:0] wd_r;
  logic        wb_hit;
  logic        is_reg;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign is_reg = (addr_r - mem_base_config_i) < APERTURE_OFFSET;

  // ****************************************
  // Wishbone slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      addr_r   <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && wb_we_i && wb_adr_i == HREG_ADDR && wb_sel_i == 4'hf)
        addr_r <= {wb_dat_i[31:2], 2'b00};
      unique case (wb_adr_i)
        HREG_ADDR:   wb_dat_o <= addr_r;
        HREG_DATA:   wb_dat_o <= data_r;
        HREG_STATUS: wb_dat_o <= {30'd0, idle_ok_r, st_r != H_IDLE};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Link sequencing
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= H_IDLE;
      data_r    <= 32'h0000_0000;
      idle_ok_r <= 1'b0;
      clean_r   <= 2'd0;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      la_r      <= 32'h0000_0000;
      be_r      <= 4'h0;
      wd_r      <= 32'h0000_0000;
    end else begin
      unique case (st_r)
        H_IDLE: begin
          if (wb_hit && wb_we_i && wb_adr_i == HREG_DATA && wb_sel_i == 4'hf)
            data_r <= wb_dat_i;
          if (wb_hit && wb_we_i && wb_adr_i == HREG_CTRL && wb_sel_i == 4'hf) begin
            if (wb_dat_i[HCTRL_IDLE]) begin
              idle_ok_r <= 1'b0;
              clean_r   <= 2'd0;
              req_r     <= 1'b1;
              we_r      <= 1'b1;
              la_r      <= mem_base_config_i + REG_FLUSH_CMD;
              be_r      <= 4'hf;
              wd_r      <= 32'h0000_0000;
              st_r      <= H_FLUSH;
            end else if (wb_dat_i[HCTRL_GO]) begin
              req_r <= 1'b1;
              we_r  <= wb_dat_i[HCTRL_WRITE];
              la_r  <= addr_r;
              be_r  <= is_reg ? 4'hf : wb_dat_i[HCTRL_BE_LSB +: 4];
              wd_r  <= data_r;
              st_r  <= H_XFER;
            end
          end
        end
        H_XFER: if (link.ack) begin
          req_r <= 1'b0;
          if (!we_r)
            data_r <= link.rdata;
          st_r <= H_IDLE;
        end
        H_FLUSH: if (link.ack) begin
          req_r <= 1'b0;
          we_r  <= 1'b0;
          la_r  <= mem_base_config_i + REG_STATUS;
          st_r  <= H_POLL;
        end
        H_POLL: begin
          if (!req_r) begin
            req_r <= 1'b1;
          end else if (link.ack) begin
            req_r <= 1'b0;
            if (link.rdata[STATUS_BUSY_BIT]) begin
              st_r <= H_IDLE; // Busy seen: report not idle
            end else if (clean_r == 2'(IDLE_READS - 1)) begin
              idle_ok_r <= 1'b1;
              st_r      <= H_IDLE;
            end else begin
              clean_r <= clean_r + 2'd1;
            end
          end
        end
      endcase
    end
  end

  assign link.req   = req_r;
  assign link.we    = we_r;
  assign link.addr  = la_r;
  assign link.be    = be_r;
  assign link.wdata = wd_r;

endmodule // lfb_host

// >>> verification/lfb_link_monitor.sv
// Purpose: Protocol checker on the link between host and device ends
// Assumes: One clock, synchronous active-high reset
// Notes:   Link addresses are absolute, so the memory base comes in as a parameter
module lfb_link_monitor import lfb_pkg::*; #(
  parameter logic [31:0] MEM_BASE = 32'h1000_0000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req,
  input wire logic        we,
  input wire logic [31:0] addr,
  input wire logic [3:0]  be,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Decode
  // ****************
  logic [31:0] rel;
  logic        is_ap;
  logic        is_reg;
  assign rel    = addr - MEM_BASE;
  assign is_ap  = (rel - APERTURE_OFFSET) < APERTURE_SIZE;
  assign is_reg = rel >= REG_FMT_CTRL && rel <= REG_STATUS;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************
  // Checks
  // ****************
  a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack held too long");
  a_ack_needs_req: assert property (ack |-> req) else $error("ack without request");
  a_req_released: assert property (ack |=> !req) else $error("request not dropped");
  // Host may re-request after one idle cycle, so only check that a drop follows an ack
  a_req_drop_acked: assert property ($fell(req) |-> $past(ack)) else $error("request withdrawn before ack");
  a_req_held_stable: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(be)
    && $stable(wdata)) else $error("request changed before ack");
  // Only aperture reads may block; everything else is answered next cycle
  a_quick_answer: assert property ($rose(req) && (we || !is_ap) |=> ack) else $error("late answer");
  a_unmapped_zero: assert property (ack && !we && !is_ap && !is_reg |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_reg_full_word: assert property (req && is_reg |-> be == 4'hf)
    else $error("partial register access");
  a_rdata_holds: assert property (ack && !we |=> $stable(rdata)) else $error("read data not held");

  c_ap_write: cover property ($rose(req) && we && is_ap);
  c_ap_read: cover property (ack && !we && is_ap);
  c_reg_write: cover property (ack && we && is_reg);
endmodule // lfb_link_monitor

// >>> verification/linear_frame_buffer_access_tb.sv
// Purpose: Self-checking bench joining host end and device end
// Assumes: Classic Wishbone master, 25 MHz clock
// Notes:   Expected pixels worked out from coordinates and format code
module linear_frame_buffer_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lfb_pkg::*;
  localparam logic [31:0] BASE = 32'h1000_0000;
  localparam logic [10:0] SW = 11'd640;
  localparam logic [10:0] SH = 11'd480;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        fifo_empty = 1'b1;
  logic        pipe_idle = 1'b1;
  logic [31:0] pix_rdata_i = 32'h0;
  logic        pix_rvalid_i = 1'b0;
  logic [1:0]  pix_col_we_o, pix_dep_we_o, acc_col = 2'h0, acc_dep = 2'h0;
  logic [3:0]  pix_be_o;
  logic [10:0] pix_x_o, pix_y_o;
  logic [31:0] pix_color0_o, pix_color1_o, rd_val = 32'h0, cda, q, r;
  logic [15:0] pix_depth0_o, pix_depth1_o;
  logic        pix_re_o, flush_o, stats_clear_o, clr = 1'b0;
  int          nre = 0, nfl = 0, nst = 0, n0, n1, seed = 45, miscompares = 0, comparisons = 0;

  lfb_link_if link ();
  lfb_host u_lfb_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .mem_base_config_i(BASE), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  lfb_device #(.SCREEN_W(SW), .SCREEN_H(SH)) u_lfb_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .mem_base_config_i(BASE), .host_fifo_empty_i(fifo_empty), .pipe_idle_i(pipe_idle), .pix_rdata_i(pix_rdata_i),
    .pix_rvalid_i(pix_rvalid_i), .pix_col_we_o(pix_col_we_o), .pix_dep_we_o(pix_dep_we_o), .pix_be_o(pix_be_o),
    .pix_x_o(pix_x_o), .pix_y_o(pix_y_o), .pix_color0_o(pix_color0_o), .pix_color1_o(pix_color1_o),
    .pix_depth0_o(pix_depth0_o), .pix_depth1_o(pix_depth1_o), .pix_re_o(pix_re_o), .flush_o(flush_o),
    .stats_clear_o(stats_clear_o));
  lfb_link_monitor #(.MEM_BASE(BASE)) u_lfb_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .req(link.req),
    .we(link.we), .addr(link.addr), .be(link.be), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  always #20 clk_i = ~clk_i;

  // ****************
  // Frame store stand-in
  // ****************
  // Idle read data toggles so a stale value never looks right
  always @(posedge clk_i) begin
    acc_col <= clr ? 2'h0 : acc_col | pix_col_we_o;
    acc_dep <= clr ? 2'h0 : acc_dep | pix_dep_we_o;
    nre <= nre + int'(pix_re_o);
    nfl <= nfl + int'(flush_o);
    nst <= nst + int'(stats_clear_o);
    pix_rvalid_i <= pix_re_o;
    pix_rdata_i <= pix_re_o ? rd_val : ~pix_rdata_i;
  end

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic w, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic go(input logic [31:0] a, input logic w, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] s;
    clr <= 1'b1;
    wb(HREG_ADDR, a, 1'b1, s);
    clr <= 1'b0;
    wb(HREG_DATA, d, 1'b1, s);
    wb(HREG_CTRL, {24'h0, be, 2'b00, w, 1'b1}, 1'b1, s);
  endtask

  task automatic wait_done(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      wb(HREG_STATUS, 32'h0, 1'b0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 400);
    if (s[0] !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic op(input logic [31:0] a, input logic w, input logic [3:0] be, input logic [31:0] d,
                    output logic [31:0] rd);
    go(a, w, be, d);
    wait_done(rd);
    wb(HREG_DATA, 32'h0, 1'b0, rd);
  endtask

  function automatic logic [31:0] argb(input logic [1:0] c, input logic [31:0] w);
    case (c)
      2'd1:    return {w[31:24], w[7:0], w[15:8], w[23:16]};
      2'd2:    return {w[7:0], w[31:8]};
      2'd3:    return {w[7:0], w[15:8], w[23:16], w[31:24]};
      default: return w;
    endcase
  endfunction

  task automatic pix(input logic [3:0] fmt, input logic sw, input logic [1:0] ch, input logic [31:0] mode,
                     input logic [10:0] line, input logic [10:0] col, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] off, s;
    logic [10:0] ey;
    logic [15:0] lo, hi;
    logic        w16;
    ey = mode[MODE_YBOT_BIT] ? SH - 11'd1 - line : line;
    lo = sw ? d[31:16] : d[15:0];
    hi = sw ? d[15:0] : d[31:16];
    w16 = fmt < 4'h4 || fmt == F_DEP_DEP;
    off = w16 ? {10'h0, line, col[9:0], 1'b0} : {9'h0, line, col[9:0], 2'b00};
    op(BASE + REG_FMT_CTRL, 1'b1, 4'hf, {19'h0, 1'b0, sw, ch, 5'h0, fmt}, s);
    op(BASE + REG_PIPE_MODE, 1'b1, 4'hf, mode, s);
    op(BASE + APERTURE_OFFSET + off, 1'b1, be, d, s);
    if ((mode[MODE_SCISSOR_BIT] && col >= SW) || (fmt > 4'h5 && fmt < 4'hc)) begin
      check({acc_col, acc_dep}, 4'h0);
    end else begin
      check(pix_x_o, col);
      check(pix_y_o, ey);
      check(pix_be_o, be);
      if (be == 4'hf && fmt < 4'h4) begin
        check(acc_col, 2'b11);
        check(pix_depth0_o, cda[15:0]);
        check(pix_color0_o[31:24], fmt == F_RSVD3 ? {8{lo[15]}} : cda[31:24]);
        check(pix_color1_o[31:24], fmt == F_RSVD3 ? {8{hi[15]}} : cda[31:24]);
        check(pix_color0_o[23:16], fmt == F_RGB565 ? {lo[15:11], lo[15:13]} : {lo[14:10], lo[14:12]});
      end else if (be == 4'hf && fmt < 4'h6) begin
        check(acc_col, 2'b01);
        check(pix_color0_o, argb(ch, d));
      end else if (be == 4'hf && fmt == F_DEP_DEP) begin
        check({acc_dep, pix_depth0_o}, {2'b11, lo});
        check(pix_depth1_o, hi);
      end else if (be == 4'hf) begin
        check({acc_col[0], acc_dep[0], pix_depth0_o}, {2'b11, hi});
        if (fmt != F_DEP_1555) check(pix_color0_o[31:24], cda[31:24]);
      end
    end
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cda = $random(seed);
    op(BASE + REG_CONST_DA, 1'b1, 4'h3, cda, q);
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      pix(4'(i), r[0], 2'd0, {15'h0, r[1], 15'h0, r[2]}, 11'(r[15:0] % 16'd480),
          11'(r[31:16] % 16'd640) & 11'h7fe, 4'hf, $random(seed));
    end
    for (int c = 0; c < 4; c++) pix(F_ARGB8888, 1'b0, 2'(c), 32'h0, 11'd7, 11'd9, 4'hf, $random(seed));
    pix(F_RGB565, 1'b0, 2'd0, 32'h0001_0000, SH - 11'd1, SW - 11'd2, 4'hf, $random(seed));
    pix(F_ARGB8888, 1'b0, 2'd0, 32'h0000_0001, 11'd3, 11'd700, 4'hf, $random(seed));
    pix(F_ARGB8888, 1'b0, 2'd0, 32'h0, 11'd1, 11'd1, 4'h3, $random(seed));
    op(BASE + 32'h200, 1'b0, 4'hf, 32'h0, q);
    check(q, 32'h0);
    op(BASE + APERTURE_OFFSET + APERTURE_SIZE, 1'b1, 4'hf, 32'h1234_5678, q);
    check({acc_col, acc_dep}, 4'h0);
    wb(HREG_ADDR, 32'h1234_5673, 1'b1, q);
    wb(HREG_ADDR, 32'h0, 1'b0, q);
    check(q, 32'h1234_5670);
    wb(HREG_CTRL, 32'h4, 1'b1, q);
    wait_done(q);
    check(q[1], 1'b1);
    // Reads must hold off while either drain condition is false
    for (int k = 0; k < 2; k++) begin
      fifo_empty <= k[0];
      pipe_idle <= ~k[0];
      rd_val = $random(seed);
      n0 = nre;
      go(BASE + APERTURE_OFFSET + 32'h1000, 1'b0, 4'hf, 32'h0);
      repeat (20) @(posedge clk_i);
      check(nre - n0, 0);
      fifo_empty <= 1'b1;
      pipe_idle <= 1'b1;
      wait_done(q);
      wb(HREG_DATA, 32'h0, 1'b0, q);
      check(q, rd_val);
      check(nre - n0, 1);
    end
    for (int k = 0; k < 2; k++) begin
      n0 = nfl;
      n1 = nst;
      op(BASE + REG_FLUSH_CMD, 1'b1, 4'hf, k, q);
      check(nfl - n0, 1);
      check(nst - n1, k);
    end
    for (int k = 1; k >= 0; k--) begin
      fifo_empty <= k[0];
      n0 = nfl;
      wb(HREG_CTRL, 32'h4, 1'b1, q);
      wait_done(q);
      check(q[1], k[0]);
      check(nfl - n0, 1);
    end
    fifo_empty <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    op(BASE + REG_STATUS, 1'b0, 4'hf, 32'h0, q);
    check(q[0], 1'b0);
    stop_test();
  end
endmodule // linear_frame_buffer_access_tb
